/* File: design/tcp_core.sv */
// timer counter and prescaler core with an apb register slave
module tcp_core
    import tcp_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EXT_COUNT_CLK,
    output logic [CNT_W-1:0] COUNT_VALUE
);

    typedef enum logic [1:0] {
        TCP_LATCH_IDLE = 2'b01,
        TCP_LATCH_HELD = 2'b10
    } tcp_latch_e;

    logic halt_r;
    logic [2:0] ps_r;
    logic [CNT_W-1:0] cnt_r;
    logic [5:0] pre_r;
    logic [7:0] held_low_r;
    tcp_latch_e latch_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic tick;
    logic sw_rst;
    logic acc;
    logic wr_ctrl;
    logic rd_hi;
    logic rd_lo;
    logic [31:0] rdata_nxt;
    logic err_nxt;

    // returns one when the prescaler has reached the tap for this code
    function automatic logic pre_tap(input logic [2:0] code,
                                     input logic [5:0] pre);
        logic [5:0] mask;
        mask = 6'h00;
        for (int i = 0; i < 6; i++)
        begin
            if (i < int'(code))
            begin
                mask[i] = 1'b1;
            end
        end
        return (pre & mask) == mask;
    endfunction

    assign acc = PSEL && PENABLE;
    assign wr_ctrl = acc && PWRITE && (PADDR == TCP_OFS_CTRL);
    assign rd_hi = acc && !PWRITE && (PADDR == TCP_OFS_CNTH);
    assign rd_lo = acc && !PWRITE && (PADDR == TCP_OFS_CNTL);
    // write of one requests reset; a zero does nothing
    assign sw_rst = wr_ctrl && PWDATA[TCP_RST_BIT];

    // external pin synchroniser, edge seen only after stage two
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end
        else
        begin
            ext_s1_r <= EXT_COUNT_CLK;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    always_comb
    begin
        if (ps_r == TCP_PS_EXT)
        begin
            tick = ext_s2_r && !ext_s3_r;
        end
        else
        begin
            tick = pre_tap(ps_r, pre_r);
        end
    end

    // control bits; the reset bit is never stored
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            halt_r <= TCP_HALT_RESET;
            ps_r <= TCP_PS_RESET;
        end
        else if (wr_ctrl)
        begin
            halt_r <= PWDATA[TCP_HALT_BIT];
            ps_r <= PWDATA[TCP_PS_LSB+:3];
        end
    end

    // prescaler runs while the counter runs
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N || sw_rst)
        begin
            pre_r <= TCP_PRE_RESET;
        end
        else if (!halt_r)
        begin
            pre_r <= pre_r + 6'h01;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N || sw_rst)
        begin
            cnt_r <= CNT_W'(TCP_CNT_RESET);
        end
        else if (!halt_r && tick)
        begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    // low byte hold buffer
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N || sw_rst)
        begin
            latch_r <= TCP_LATCH_IDLE;
            held_low_r <= 8'h00;
        end
        else if (rd_lo)
        begin
            latch_r <= TCP_LATCH_IDLE;
        end
        else if (rd_hi)
        begin
            case (latch_r)
                TCP_LATCH_IDLE:
                begin
                    latch_r <= TCP_LATCH_HELD;
                    held_low_r <= cnt_r[7:0];
                end
                default:
                begin
                    latch_r <= TCP_LATCH_HELD;
                end
            endcase
        end
    end

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (PADDR == TCP_OFS_CTRL)
        begin
            rdata_nxt[TCP_HALT_BIT] = halt_r;
            rdata_nxt[TCP_PS_LSB+:3] = ps_r; // reset bit reads zero
        end
        else if (PADDR == TCP_OFS_CNTH)
        begin
            rdata_nxt[7:0] = cnt_r[15:8];
            err_nxt = PWRITE;
        end
        else if (PADDR == TCP_OFS_CNTL)
        begin
            if (latch_r == TCP_LATCH_HELD)
            begin
                rdata_nxt[7:0] = held_low_r;
            end
            else
            begin
                rdata_nxt[7:0] = cnt_r[7:0];
            end
            err_nxt = PWRITE; // count bytes ignore writes
        end
        else
        begin
            err_nxt = 1'b1;
        end
    end

    // registered outputs; answer arrives in the first access cycle
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            COUNT_VALUE <= '0;
        end
        else
        begin
            PREADY <= PSEL && !PENABLE;
            PRDATA <= rdata_nxt;
            PSLVERR <= err_nxt && PSEL && !PENABLE;
            COUNT_VALUE <= cnt_r;
        end
    end

    property p_rst_clears;
        @(posedge SYS_CLK) disable iff (!RST_N)
        sw_rst |=> cnt_r == '0 && pre_r == '0;
    endproperty
    a_rst_clears: assert property (p_rst_clears)
        else $error("counter not cleared by reset bit");
    property p_restart;
        @(posedge SYS_CLK) disable iff (!RST_N)
        sw_rst && !PWDATA[TCP_HALT_BIT] && PWDATA[2:0] == 3'h0
            ##1 !sw_rst && !wr_ctrl |=> cnt_r == CNT_W'(1);
    endproperty
    a_restart: assert property (p_restart)
        else $error("counter did not restart from zero");
    property p_rst_reads_zero;
        @(posedge SYS_CLK) disable iff (!RST_N)
        PSEL && !PENABLE && PADDR == TCP_OFS_CTRL |=> PRDATA[TCP_RST_BIT] == 0;
    endproperty
    a_rst_reads_zero: assert property (p_rst_reads_zero)
        else $error("reset bit read back as one");
    property p_halt_zero;
        @(posedge SYS_CLK) disable iff (!RST_N)
        sw_rst && PWDATA[TCP_HALT_BIT] ##1 !wr_ctrl [*3] |-> cnt_r == '0;
    endproperty
    a_halt_zero: assert property (p_halt_zero)
        else $error("halted counter left zero");
    property p_div;
        @(posedge SYS_CLK) disable iff (!RST_N)
        !halt_r && ps_r == 3'h1 && $past(!halt_r) && $past(ps_r) == 3'h1
            && !$past(sw_rst) && !sw_rst |-> $changed(cnt_r) == $past(pre_r[0]);
    endproperty
    a_div: assert property (p_div)
        else $error("divide by two rate wrong");
    property p_ext;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ps_r == TCP_PS_EXT && !ext_s2_r |-> !tick;
    endproperty
    a_ext: assert property (p_ext)
        else $error("tick without external edge");
    property p_hold;
        @(posedge SYS_CLK) disable iff (!RST_N)
        halt_r && !sw_rst |=> $stable(cnt_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved while halted");
    property p_latch;
        @(posedge SYS_CLK) disable iff (!RST_N)
        latch_r == TCP_LATCH_HELD && !rd_lo && !sw_rst |=> $stable(held_low_r);
    endproperty
    a_latch: assert property (p_latch)
        else $error("held low byte overwritten");
    property p_capture;
        @(posedge SYS_CLK) disable iff (!RST_N)
        rd_hi && latch_r == TCP_LATCH_IDLE && !sw_rst
            |=> held_low_r == $past(cnt_r[7:0]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("low byte not captured");

    // system reset leaves the counter halted, undivided and empty
    property p_sys_reset;
        @(posedge SYS_CLK)
        !RST_N |=> halt_r == TCP_HALT_RESET && ps_r == TCP_PS_RESET
            && cnt_r == '0 && latch_r == TCP_LATCH_IDLE;
    endproperty
    a_sys_reset: assert property (p_sys_reset)
        else $error("state after system reset wrong");
    property p_ctrl_write;
        @(posedge SYS_CLK) disable iff (!RST_N)
        wr_ctrl |=> ps_r == $past(PWDATA[TCP_PS_LSB+:3])
            && halt_r == $past(PWDATA[TCP_HALT_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write not stored");
    property p_ext_count;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ps_r == TCP_PS_EXT && !halt_r && !sw_rst && ext_s2_r && !ext_s3_r
            |=> cnt_r == $past(cnt_r) + CNT_W'(1);
    endproperty
    a_ext_count: assert property (p_ext_count)
        else $error("external edge not counted");
    property p_ext_quiet;
        @(posedge SYS_CLK) disable iff (!RST_N)
        ps_r == TCP_PS_EXT && !sw_rst && !(ext_s2_r && !ext_s3_r)
            |=> $stable(cnt_r);
    endproperty
    a_ext_quiet: assert property (p_ext_quiet)
        else $error("counter moved without external edge");
    // count byte writes leave the count to its own clocking
    property p_count_ro;
        @(posedge SYS_CLK) disable iff (!RST_N)
        acc && PWRITE && PADDR != TCP_OFS_CTRL
            |=> cnt_r == $past(cnt_r) + CNT_W'($past(!halt_r && tick));
    endproperty
    a_count_ro: assert property (p_count_ro)
        else $error("write changed the count");
    property p_high_read;
        @(posedge SYS_CLK) disable iff (!RST_N)
        PSEL && !PENABLE && PADDR == TCP_OFS_CNTH
            |=> PRDATA == {24'h000000, $past(cnt_r[15:8])};
    endproperty
    a_high_read: assert property (p_high_read)
        else $error("high byte read wrong");
    property p_held_read;
        @(posedge SYS_CLK) disable iff (!RST_N)
        PSEL && !PENABLE && PADDR == TCP_OFS_CNTL
            && latch_r == TCP_LATCH_HELD
            |=> PRDATA[7:0] == $past(held_low_r);
    endproperty
    a_held_read: assert property (p_held_read)
        else $error("held low byte not returned");
    property p_live_read;
        @(posedge SYS_CLK) disable iff (!RST_N)
        PSEL && !PENABLE && PADDR == TCP_OFS_CNTL
            && latch_r == TCP_LATCH_IDLE
            |=> PRDATA[7:0] == $past(cnt_r[7:0]);
    endproperty
    a_live_read: assert property (p_live_read)
        else $error("live low byte not returned");
    property p_release;
        @(posedge SYS_CLK) disable iff (!RST_N)
        rd_lo || sw_rst |=> latch_r == TCP_LATCH_IDLE;
    endproperty
    a_release: assert property (p_release)
        else $error("low byte buffer not released");

    c_sw_rst: cover property (@(posedge SYS_CLK) sw_rst);
    c_ext: cover property (@(posedge SYS_CLK) ps_r == TCP_PS_EXT && tick);
    c_pair: cover property (@(posedge SYS_CLK) rd_hi ##[1:20] rd_lo);
    c_halt_rst: cover property (@(posedge SYS_CLK)
        sw_rst && PWDATA[TCP_HALT_BIT]);
    c_held_read: cover property (@(posedge SYS_CLK)
        rd_lo && latch_r == TCP_LATCH_HELD);
endmodule

/* File: inc/tcp_pkg.sv */
// package of constants for the timer counter prescaler core
// Functional notes
// - Writing one to the counter reset bit clears counter, prescaler and the low byte hold buffer and touches no other register.
// - After a software counter reset the counter restarts from zero on the next selected edges unless halted.
// - The counter reset bit clears itself, always reads zero, and writing zero does nothing.
// - A system reset clears the counter reset bit.
// - Setting halt and counter reset in one write leaves the counter stopped at zero.
// - Divider codes zero to six count the bus clock divided by 1, 2, 4, 8, 16, 32 and 64.
// - Divider code all ones counts edges of the external count clock pin.
// - System reset clears the divider select to zero; software can read and write it.
// - The count is read as two read-only byte registers that writes do not change.
// - Reading the high byte captures the low byte into a buffer returned by the next low byte read.
// - While a low byte is held, further high byte reads do not overwrite it until the low byte is read.
// - System reset and software counter reset clear both count byte registers.
// - The halt bit freezes the counter, clearing it resumes counting, and system reset sets it.
package tcp_pkg;
    localparam logic [11:0] TCP_OFS_CTRL = 12'h000;
    localparam logic [11:0] TCP_OFS_CNTH = 12'h004;
    localparam logic [11:0] TCP_OFS_CNTL = 12'h008;
    localparam int TCP_HALT_BIT = 5;
    localparam int TCP_RST_BIT = 4;
    localparam int TCP_PS_LSB = 0;
    localparam logic [2:0] TCP_PS_RESET = 3'h0;
    localparam logic [2:0] TCP_PS_EXT = 3'h7;
    localparam logic TCP_HALT_RESET = 1'b1;
    localparam logic [15:0] TCP_CNT_RESET = 16'h0000;
    localparam logic [5:0] TCP_PRE_RESET = 6'h00;
endpackage

/* File: testbench/timer_counter_prescaler_core_tb.sv */
// self-checking testbench for the timer counter prescaler core
module timer_counter_prescaler_core_tb
    import tcp_pkg::*;
;
timeunit 1ns;
timeprecision 1ns;
logic sys_clk = 1'b0;
logic rst_n = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h00000000;
logic ext_clk = 1'b0;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic [15:0] count_value;
logic [31:0] rd;
logic er;
int err_total = 0;
int compares = 0;
int cyc = 0;

always #50 sys_clk = ~sys_clk;

tcp_core uut (
    .SYS_CLK(sys_clk),
    .RST_N(rst_n),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr),
    .EXT_COUNT_CLK(ext_clk),
    .COUNT_VALUE(count_value)
);

task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
        err_total++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask

task automatic tally_and_finish();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask

// one apb transfer; holds the request until pready is sampled high
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
        @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask

task automatic reset_values();
    apb(1'b0, TCP_OFS_CTRL, 32'h0);
    chk(rd, 32'h00000020);
    apb(1'b0, TCP_OFS_CNTH, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, TCP_OFS_CNTL, 32'h0);
    chk(rd, 32'h0);
    chk({16'h0, count_value}, 32'h0);
endtask

task automatic rate_check();
    logic [15:0] a;
    for (int code = 0; code < 7; code++)
    begin
        apb(1'b1, TCP_OFS_CTRL, 32'(code));
        repeat (2) @(posedge sys_clk);
        a = count_value;
        repeat (256) @(posedge sys_clk);
        chk({16'h0, 16'(count_value - a)}, 32'(256 >> code));
        apb(1'b0, TCP_OFS_CTRL, 32'h0);
        chk(rd, 32'(code));
    end
endtask

task automatic soft_reset();
    apb(1'b1, TCP_OFS_CTRL, 32'h00000033);
    repeat (3) @(posedge sys_clk);
    chk({16'h0, count_value}, 32'h0);
    repeat (20) @(posedge sys_clk);
    chk({16'h0, count_value}, 32'h0);
    apb(1'b0, TCP_OFS_CTRL, 32'h0);
    chk(rd, 32'h00000023);
    apb(1'b0, TCP_OFS_CNTL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, TCP_OFS_CTRL, 32'h00000010);
    repeat (5) @(posedge sys_clk);
    chk({16'h0, count_value}, 32'h3);
    repeat (20) @(posedge sys_clk);
    apb(1'b1, TCP_OFS_CTRL, 32'h00000010);
    repeat (5) @(posedge sys_clk);
    chk({16'h0, count_value}, 32'h3);
endtask

task automatic latch_check();
    logic [31:0] v;
    apb(1'b1, TCP_OFS_CTRL, 32'h00000030);
    apb(1'b0, TCP_OFS_CNTH, 32'h0);
    apb(1'b1, TCP_OFS_CTRL, 32'h00000000);
    repeat (40) @(posedge sys_clk);
    apb(1'b1, TCP_OFS_CTRL, 32'h00000020);
    apb(1'b0, TCP_OFS_CNTH, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, TCP_OFS_CNTL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, TCP_OFS_CNTL, 32'h0);
    v = rd;
    chk(v, 32'h0000002B);
    apb(1'b1, TCP_OFS_CNTL, 32'h000000FF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, TCP_OFS_CNTL, 32'h0);
    chk(rd, v);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
endtask

task automatic ext_check();
    apb(1'b1, TCP_OFS_CTRL, 32'h00000037);
    apb(1'b1, TCP_OFS_CTRL, 32'h00000007);
    repeat (20) @(posedge sys_clk);
    chk({16'h0, count_value}, 32'h0);
    repeat (5)
    begin
        ext_clk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ext_clk <= 1'b0;
        repeat (4) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
    chk({16'h0, count_value}, 32'h5);
endtask

task automatic mid_reset();
    apb(1'b1, TCP_OFS_CTRL, 32'h00000005);
    repeat (30) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, TCP_OFS_CTRL, 32'h0);
    chk(rd, 32'h00000020);
    apb(1'b0, TCP_OFS_CNTL, 32'h0);
    chk(rd, 32'h0);
endtask

always @(posedge sys_clk)
begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
        err_total++;
        tally_and_finish();
    end
end

initial
begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    reset_values();
    rate_check();
    soft_reset();
    latch_check();
    ext_check();
    mid_reset();
    tally_and_finish();
end
endmodule
